// ### src/interleave_register_address_calc.sv
// Interleave register address calculator top level
// Functional notes
// - Way count is modules per controller times participating controllers.
// - Rotation bytes equal line bytes times lines per rotation.
// - Line index is offset modulo rotation, divided by line bytes; selects table.
// - Rotation index is offset divided by rotation bytes.
// - Remainder is offset modulo line bytes, added into the result.
// - Table entry at the line index is the line offset term.
// - Address is rotation*index*ways plus entry plus remainder plus base.
// - Command/status use control range type 2; apertures use range type 3.
// - Direct range type 1 accesses bypass interleave correction.
// - Line bytes per channel request; lines before the pattern repeats.
// - Each register access is translated on its own request.
// - Without interleave, address is offset plus region base.
`include "addr_calc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module interleave_register_address_calc (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`LINE_W-1:0] cfg_line_bytes,
    input wire logic [`LINE_W-1:0] cfg_lines_per_rotation,
    input wire logic [`WAY_W-1:0] cfg_ways_per_ctrl,
    input wire logic [`WAY_W-1:0] cfg_ctrl_count,
    input wire logic cfg_interleave_on,
    input wire logic [`ADDR_W-1:0] cfg_base_direct,
    input wire logic [`ADDR_W-1:0] cfg_base_control,
    input wire logic [`ADDR_W-1:0] cfg_base_aperture,
    input wire logic tbl_we,
    input wire logic [`TBL_AW-1:0] tbl_addr,
    input wire logic [`TBL_DW-1:0] tbl_data,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [`OFS_W-1:0] req_offset,
    input wire logic [1:0] req_kind,
    output logic res_valid,
    output logic [`ADDR_W-1:0] system_phys_addr,
    output logic [1:0] res_region_type,
    output logic [`TBL_AW-1:0] res_line_index,
    output logic [`OFS_W-1:0] res_rotation_index
);

    // ------------------------------------------------------------
    // Captured request and parameters
    // ------------------------------------------------------------
    addr_calc_pkg::calc_state_e state;
    addr_calc_pkg::req_kind_e kind;
    logic [`OFS_W-1:0] offset;
    logic [`LINE_W-1:0] line_bytes;
    logic [`LINE_W-1:0] lines_per_rotation;
    logic [`WAYS_W-1:0] way_count;
    logic interleave_on;
    logic [`ADDR_W-1:0] region_base_address;
    logic [1:0] region_type;

    // ------------------------------------------------------------
    // Intermediate results
    // ------------------------------------------------------------
    logic [`OFS_W-1:0] rotation_bytes;
    logic [`OFS_W-1:0] rotation_index;
    logic [`OFS_W-1:0] rotation_rem;
    logic [`TBL_AW-1:0] line_index;
    logic [`OFS_W-1:0] remainder;
    logic [`TBL_DW-1:0] interleave_shift_entry;

    // ------------------------------------------------------------
    // Divider hookup
    // ------------------------------------------------------------
    logic div_start;
    logic div_done;
    logic [`OFS_W-1:0] div_quot;
    logic [`OFS_W-1:0] div_rem;
    logic [`OFS_W-1:0] div_dividend;
    logic [`OFS_W-1:0] div_divisor;

    // ------------------------------------------------------------
    // Decode of request and selection
    // ------------------------------------------------------------
    wire accept;
    wire st_idle;
    wire in_rot;
    wire [`WAYS_W-1:0] next_way_count;
    wire [`ADDR_W-1:0] next_base;
    wire [1:0] next_region_type;
    wire is_direct_req;
    wire is_aperture_req;
    wire bypass;
    wire [`ADDR_W-1:0] rot_term;
    wire [`ADDR_W-1:0] interleaved_addr;
    wire [`ADDR_W-1:0] flat_addr;
    wire [`ADDR_W-1:0] next_addr;

    assign st_idle = (state == addr_calc_pkg::ST_IDLE);
    assign accept = req_valid && st_idle;
    assign req_ready = st_idle;
    assign is_direct_req = (req_kind == addr_calc_pkg::KIND_DIRECT);
    assign is_aperture_req = (req_kind == addr_calc_pkg::KIND_APERTURE);

    // Ways across the whole set
    assign next_way_count = `WAYS_W'(cfg_ways_per_ctrl) * `WAYS_W'(cfg_ctrl_count);

    // Region base by address range type
    assign next_region_type = is_direct_req ? `RANGE_TYPE_DIRECT :
        (is_aperture_req ? `RANGE_TYPE_APERTURE : `RANGE_TYPE_CONTROL);
    assign next_base = is_direct_req ? cfg_base_direct :
        (is_aperture_req ? cfg_base_aperture : cfg_base_control);

    // Rotation size from captured line parameters
    assign rotation_bytes = `OFS_W'(line_bytes) * `OFS_W'(lines_per_rotation);

    // Divider operands, shared by both division passes
    assign in_rot = (state == addr_calc_pkg::ST_DIV_ROT);
    assign div_dividend = in_rot ? offset : rotation_rem;
    assign div_divisor = in_rot ? rotation_bytes : `OFS_W'(line_bytes);

    // Final address sum
    assign rot_term = `ADDR_W'(rotation_bytes) * `ADDR_W'(rotation_index)
        * `ADDR_W'(way_count);
    assign interleaved_addr = rot_term + `ADDR_W'(interleave_shift_entry)
        + `ADDR_W'(remainder) + region_base_address;
    assign flat_addr = `ADDR_W'(offset) + region_base_address;
    assign bypass = (kind == addr_calc_pkg::KIND_DIRECT) || !interleave_on;
    assign next_addr = bypass ? flat_addr : interleaved_addr;

    // ------------------------------------------------------------
    // Shared divider
    // ------------------------------------------------------------
    seq_divider u_div (
        .clk(clk),
        .rst(rst),
        .start(div_start),
        .dividend(div_dividend),
        .divisor(div_divisor),
        .done(div_done),
        .quotient(div_quot),
        .remainder(div_rem)
    );

    // ------------------------------------------------------------
    // Interleave offset table
    // ------------------------------------------------------------
    shift_table u_tbl (
        .clk(clk),
        .wr_en(tbl_we),
        .wr_addr(tbl_addr),
        .wr_data(tbl_data),
        .rd_addr(line_index),
        .rd_data(interleave_shift_entry)
    );

    // ------------------------------------------------------------
    // Parameter capture at acceptance
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            kind <= addr_calc_pkg::KIND_COMMAND;
            offset <= '0;
            line_bytes <= '0;
            lines_per_rotation <= '0;
            way_count <= '0;
            interleave_on <= 1'b0;
            region_base_address <= '0;
            region_type <= '0;
        end else if (accept) begin
            kind <= addr_calc_pkg::req_kind_e'(req_kind);
            offset <= req_offset;
            line_bytes <= cfg_line_bytes;
            lines_per_rotation <= cfg_lines_per_rotation;
            way_count <= next_way_count;
            interleave_on <= cfg_interleave_on;
            region_base_address <= next_base;
            region_type <= next_region_type;
        end
    end

    // ------------------------------------------------------------
    // State decode
    // ------------------------------------------------------------
    wire st_div_line;
    wire st_sum;
    wire rot_done;
    wire line_done;
    addr_calc_pkg::calc_state_e next_state;

    assign st_div_line = (state == addr_calc_pkg::ST_DIV_LINE);
    assign st_sum = (state == addr_calc_pkg::ST_SUM);
    assign rot_done = in_rot && div_done;
    assign line_done = st_div_line && div_done;

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            addr_calc_pkg::ST_IDLE: begin
                if (accept) begin
                    next_state = addr_calc_pkg::ST_DIV_ROT;
                end
            end
            addr_calc_pkg::ST_DIV_ROT: begin
                if (div_done) begin
                    next_state = addr_calc_pkg::ST_DIV_LINE;
                end
            end
            addr_calc_pkg::ST_DIV_LINE: begin
                if (div_done) begin
                    next_state = addr_calc_pkg::ST_LOOKUP;
                end
            end
            addr_calc_pkg::ST_LOOKUP: begin
                next_state = addr_calc_pkg::ST_SUM;
            end
            addr_calc_pkg::ST_SUM: begin
                next_state = addr_calc_pkg::ST_IDLE;
            end
            default: begin
                next_state = addr_calc_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= addr_calc_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Divider start, once per pass
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_start <= 1'b0;
        end else begin
            div_start <= accept || rot_done;
        end
    end

    // ------------------------------------------------------------
    // Rotation pass results
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rotation_index <= '0;
            rotation_rem <= '0;
        end else if (rot_done) begin
            rotation_index <= div_quot;
            rotation_rem <= div_rem;
        end
    end

    // ------------------------------------------------------------
    // Line pass results
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_index <= '0;
            remainder <= '0;
        end else if (line_done) begin
            line_index <= div_quot[`TBL_AW-1:0];
            remainder <= div_rem;
        end
    end

    // ------------------------------------------------------------
    // Result pulse
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_valid <= 1'b0;
        end else begin
            res_valid <= st_sum;
        end
    end

    // ------------------------------------------------------------
    // Result data
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            system_phys_addr <= '0;
            res_region_type <= '0;
            res_line_index <= '0;
            res_rotation_index <= '0;
        end else if (st_sum) begin
            system_phys_addr <= next_addr;
            res_region_type <= region_type;
            res_line_index <= line_index;
            res_rotation_index <= rotation_index;
        end
    end

endmodule : interleave_register_address_calc

`default_nettype wire

// ### src/addr_calc_defs.svh
// Constants for the interleave register address calculator
`ifndef ADDR_CALC_DEFS_SVH
`define ADDR_CALC_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define ADDR_W 64
`define OFS_W 32
`define LINE_W 16
`define WAY_W 8
`define WAYS_W 16
`define TBL_AW 8
`define TBL_DW 32
`define TBL_DEPTH 256
`define DIV_CNT_W 5

// ----------------------------------------------------------------
// Address range types
// ----------------------------------------------------------------
`define RANGE_TYPE_DIRECT 2'h1
`define RANGE_TYPE_CONTROL 2'h2
`define RANGE_TYPE_APERTURE 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DIV_LAST_STEP 5'h1F
`define ADDR_CALC_LATENCY 70

`endif

// ### src/addr_calc_pkg.sv
// Types for the interleave register address calculator
package addr_calc_pkg;

    // ------------------------------------------------------------
    // Request kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_COMMAND = 2'b00,
        KIND_STATUS = 2'b01,
        KIND_APERTURE = 2'b10,
        KIND_DIRECT = 2'b11
    } req_kind_e;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DIV_ROT = 3'b001,
        ST_DIV_LINE = 3'b010,
        ST_LOOKUP = 3'b011,
        ST_SUM = 3'b100
    } calc_state_e;

endpackage : addr_calc_pkg

// ### src/seq_divider.sv
// Sequential restoring divider, one quotient bit per cycle
`include "addr_calc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module seq_divider (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [`OFS_W-1:0] dividend,
    input wire logic [`OFS_W-1:0] divisor,
    output logic done,
    output logic [`OFS_W-1:0] quotient,
    output logic [`OFS_W-1:0] remainder
);

    logic busy;
    logic [`DIV_CNT_W-1:0] step;
    logic [`OFS_W:0] trial;
    logic [`OFS_W-1:0] next_rem;
    logic fits;

    // ------------------------------------------------------------
    // Trial subtraction
    // ------------------------------------------------------------
    assign trial = {remainder, quotient[`OFS_W-1]} - {1'b0, divisor};
    assign fits = ~trial[`OFS_W];
    assign next_rem = fits ? trial[`OFS_W-1:0] : {remainder[`OFS_W-2:0], quotient[`OFS_W-1]};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            step <= '0;
            quotient <= '0;
            remainder <= '0;
        end else if (start) begin
            busy <= 1'b1;
            done <= 1'b0;
            step <= '0;
            quotient <= dividend;
            remainder <= '0;
        end else if (busy) begin
            quotient <= {quotient[`OFS_W-2:0], fits};
            remainder <= next_rem;
            step <= step + `DIV_CNT_W'(1);
            busy <= (step != `DIV_LAST_STEP);
            done <= (step == `DIV_LAST_STEP);
        end else begin
            done <= 1'b0;
        end
    end

endmodule : seq_divider

`default_nettype wire

// ### src/shift_table.sv
// Per-line interleave offset table with registered read
`include "addr_calc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module shift_table (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [`TBL_AW-1:0] wr_addr,
    input wire logic [`TBL_DW-1:0] wr_data,
    input wire logic [`TBL_AW-1:0] rd_addr,
    output logic [`TBL_DW-1:0] rd_data
);

    logic [`TBL_DW-1:0] entries [0:`TBL_DEPTH-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            entries[wr_addr] <= wr_data;
        end
        rd_data <= entries[rd_addr];
    end

endmodule : shift_table

`default_nettype wire

// ### verification/interleave_register_address_calc_sva.sv
// Assertion checker for the interleave register address calculator
`include "addr_calc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module interleave_register_address_calc_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`LINE_W-1:0] cfg_line_bytes,
    input wire logic [`LINE_W-1:0] cfg_lines_per_rotation,
    input wire logic cfg_interleave_on,
    input wire logic [`ADDR_W-1:0] cfg_base_direct,
    input wire logic [`ADDR_W-1:0] cfg_base_control,
    input wire logic [`ADDR_W-1:0] cfg_base_aperture,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [`OFS_W-1:0] req_offset,
    input wire logic [1:0] req_kind,
    input wire logic res_valid,
    input wire logic [`ADDR_W-1:0] system_phys_addr,
    input wire logic [1:0] res_region_type,
    input wire logic [`TBL_AW-1:0] res_line_index,
    input wire logic [`OFS_W-1:0] res_rotation_index
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    logic [31:0] ofs_q, rot_q;
    logic [15:0] lb_q;
    logic [1:0] kind_q;
    logic on_q;
    logic [63:0] base_q;
    wire logic take = req_valid && req_ready;
    wire logic [63:0] base_sel = (req_kind == 2'h3) ? cfg_base_direct :
        (req_kind == 2'h2) ? cfg_base_aperture : cfg_base_control;
    wire logic [1:0] type_exp = (kind_q == 2'h3) ? `RANGE_TYPE_DIRECT :
        (kind_q == 2'h2) ? `RANGE_TYPE_APERTURE : `RANGE_TYPE_CONTROL;
    wire logic bypass = (kind_q == 2'h3) || !on_q;
    always_ff @(posedge clk) begin
        if (take) begin
            ofs_q <= req_offset;
            rot_q <= 32'(cfg_line_bytes) * 32'(cfg_lines_per_rotation);
            lb_q <= cfg_line_bytes;
            kind_q <= req_kind;
            on_q <= cfg_interleave_on;
            base_q <= base_sel;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_latency;
        take |-> ##71 res_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("result not at fixed latency");
    property p_busy;
        take |=> (!req_ready && !res_valid) [*8];
    endproperty
    a_busy: assert property (p_busy) else $error("ready or result right after accept");
    property p_ready;
        res_valid |-> req_ready;
    endproperty
    a_ready: assert property (p_ready) else $error("not ready during result");
    property p_pulse;
        res_valid |=> !res_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("result valid longer than one cycle");
    property p_hold;
        !res_valid |-> $stable(system_phys_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("address changed without result");
    property p_region;
        res_valid |-> res_region_type == type_exp;
    endproperty
    a_region: assert property (p_region) else $error("wrong region type");
    property p_bypass;
        res_valid && bypass |-> system_phys_addr == 64'(ofs_q) + base_q;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass address wrong");
    property p_line;
        res_valid && !bypass |-> res_line_index == 8'((ofs_q % rot_q) / 32'(lb_q));
    endproperty
    a_line: assert property (p_line) else $error("line index wrong");
    property p_rot;
        res_valid && !bypass |-> res_rotation_index == ofs_q / rot_q;
    endproperty
    a_rot: assert property (p_rot) else $error("rotation index wrong");
    c_direct: cover property (take && req_kind == 2'h3);
    c_interleave: cover property (res_valid && !bypass);
    c_refused: cover property (take ##1 (req_valid && !req_ready));
endmodule : interleave_register_address_calc_sva

bind interleave_register_address_calc interleave_register_address_calc_sva i_sva (
    .clk(clk), .rst(rst), .cfg_line_bytes(cfg_line_bytes),
    .cfg_lines_per_rotation(cfg_lines_per_rotation), .cfg_interleave_on(cfg_interleave_on),
    .cfg_base_direct(cfg_base_direct), .cfg_base_control(cfg_base_control),
    .cfg_base_aperture(cfg_base_aperture), .req_valid(req_valid), .req_ready(req_ready),
    .req_offset(req_offset), .req_kind(req_kind), .res_valid(res_valid),
    .system_phys_addr(system_phys_addr), .res_region_type(res_region_type),
    .res_line_index(res_line_index), .res_rotation_index(res_rotation_index));

`default_nettype wire

// ### verification/tb_interleave_register_address_calc.sv
// Testbench for the interleave register address calculator
`include "addr_calc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_interleave_register_address_calc;
    logic clk, rst, tbl_we, req_valid, req_ready, res_valid, cfg_interleave_on;
    logic [`LINE_W-1:0] cfg_line_bytes, cfg_lines_per_rotation;
    logic [`WAY_W-1:0] cfg_ways_per_ctrl, cfg_ctrl_count;
    logic [`TBL_AW-1:0] tbl_addr, res_line_index;
    logic [`ADDR_W-1:0] cfg_base_direct, cfg_base_control, cfg_base_aperture, system_phys_addr;
    logic [`OFS_W-1:0] tbl_data, req_offset, res_rotation_index;
    logic [1:0] req_kind, res_region_type;
    int miscompares = 0;
    int total_checks = 0;
    int lat;

    interleave_register_address_calc i_dut (
        .clk(clk), .rst(rst), .cfg_line_bytes(cfg_line_bytes),
        .cfg_lines_per_rotation(cfg_lines_per_rotation), .cfg_ways_per_ctrl(cfg_ways_per_ctrl),
        .cfg_ctrl_count(cfg_ctrl_count), .cfg_interleave_on(cfg_interleave_on),
        .cfg_base_direct(cfg_base_direct), .cfg_base_control(cfg_base_control),
        .cfg_base_aperture(cfg_base_aperture), .tbl_we(tbl_we), .tbl_addr(tbl_addr),
        .tbl_data(tbl_data), .req_valid(req_valid), .req_ready(req_ready),
        .req_offset(req_offset), .req_kind(req_kind), .res_valid(res_valid),
        .system_phys_addr(system_phys_addr), .res_region_type(res_region_type),
        .res_line_index(res_line_index), .res_rotation_index(res_rotation_index));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic results;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    function automatic logic [63:0] tbl_val(input logic [31:0] i);
        return 64'(i) * 64'h100 + 64'h7;
    endfunction : tbl_val

    task automatic go(input logic [1:0] kind, input logic [31:0] ofs, input bit poke);
        req_kind = kind;
        req_offset = ofs;
        req_valid = 1'b1;
        @(posedge clk);
        #1;
        lat = 0;
        if (poke) begin
            req_offset = ~ofs;
        end
        for (int i = 1; i <= 100 && lat == 0; i++) begin
            req_valid = poke && (i == 5);
            @(posedge clk);
            #1;
            if (res_valid === 1'b1) begin
                lat = i;
            end
        end
        if (lat == 0) begin
            miscompares++;
            results();
        end
    endtask : go

    task automatic one(input logic [1:0] kind, input logic [31:0] ofs, input bit poke);
        logic [31:0] rot;
        logic [63:0] base;
        bit byp;
        rot = 32'(cfg_line_bytes) * 32'(cfg_lines_per_rotation);
        base = (kind == 2'h3) ? cfg_base_direct : (kind == 2'h2) ? cfg_base_aperture
            : cfg_base_control;
        byp = (kind == 2'h3) || !cfg_interleave_on;
        go(kind, ofs, poke);
        check(64'(lat), 64'(`ADDR_CALC_LATENCY));
        check(64'(req_ready), 64'h1);
        check(64'(res_region_type), (kind == 2'h3) ? 64'h1 : (kind == 2'h2) ? 64'h3 : 64'h2);
        if (byp) begin
            check(system_phys_addr, 64'(ofs) + base);
        end else begin
            check(64'(res_rotation_index), 64'(ofs / rot));
            check(64'(res_line_index), 64'(8'((ofs % rot) / 32'(cfg_line_bytes))));
            check(system_phys_addr, 64'(rot) * 64'(ofs / rot) * 64'(cfg_ways_per_ctrl)
                * 64'(cfg_ctrl_count) + tbl_val((ofs % rot) / 32'(cfg_line_bytes))
                + 64'(ofs % 32'(cfg_line_bytes)) + base);
        end
    endtask : one

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_interleave;
        logic [31:0] ofs [6] = '{32'h0, 32'h3FF, 32'h400, 32'hA37, 32'h12345678, 32'hFFFFFFFF};
        for (int i = 0; i < 6; i++) begin
            one(2'(i % 3), ofs[i], 1'b0);
        end
    endtask : t_interleave

    task automatic t_geometry;
        cfg_line_bytes = 16'h40;
        cfg_lines_per_rotation = 16'h8;
        cfg_ways_per_ctrl = 8'h1;
        cfg_ctrl_count = 8'h4;
        one(2'h2, 32'h00000A37, 1'b1);
        one(2'h0, 32'h000001FF, 1'b0);
    endtask : t_geometry

    task automatic t_bypass;
        one(2'h3, 32'h00ABCDEF, 1'b0);
        cfg_interleave_on = 1'b0;
        one(2'h1, 32'h00001234, 1'b0);
        one(2'h2, 32'h00000777, 1'b0);
        cfg_interleave_on = 1'b1;
    endtask : t_bypass

    task automatic t_reset;
        req_kind = 2'h0;
        req_valid = 1'b1;
        repeat (10) @(posedge clk);
        #1 req_valid = 1'b0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(64'(res_valid), 64'h0);
        check(64'(req_ready), 64'h1);
        check(system_phys_addr, 64'h0);
        rst = 1'b0;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk);
            #1;
            if (res_valid !== 1'b0) begin
                check(64'(res_valid), 64'h0);
            end
        end
        one(2'h1, 32'h00000A37, 1'b0);
    endtask : t_reset

    initial begin
        rst = 1'b1;
        {tbl_we, req_valid, req_offset, req_kind, tbl_addr, tbl_data} = '0;
        cfg_line_bytes = 16'h100;
        cfg_lines_per_rotation = 16'h4;
        cfg_ways_per_ctrl = 8'h3;
        cfg_ctrl_count = 8'h2;
        cfg_interleave_on = 1'b1;
        cfg_base_direct = 64'h0000001000000000;
        cfg_base_control = 64'h0000002000000000;
        cfg_base_aperture = 64'h0000003000000000;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 256; i++) begin
            tbl_we = 1'b1;
            tbl_addr = 8'(i);
            tbl_data = 32'(tbl_val(32'(i)));
            @(posedge clk);
            #1;
        end
        tbl_we = 1'b0;
        t_interleave();
        t_bypass();
        t_reset();
        t_geometry();
        results();
    end
endmodule : tb_interleave_register_address_calc

`default_nettype wire
